// *** pkg/rwn_regs.vh ***
/*
 Command opcodes, field positions and reset values for the RAM update
 window and nonvolatile control command interpreter.
 Assumes a host that frames bytes with a command/data select.
*/
`ifndef RWN_REGS_VH
`define RWN_REGS_VH
`define RWN_OP_WIN_SC      8'hF4
`define RWN_OP_WIN_SR      8'hF5
`define RWN_OP_WIN_EC      8'hF6
`define RWN_OP_WIN_ER      8'hF7
`define RWN_OP_WIN_EN_MASK 8'hFE
`define RWN_OP_WIN_EN      8'hF8
`define RWN_OP_NVM_CTL     8'hB8
`define RWN_OP_NVM_MASK    8'hB9
`define RWN_OP_DISP_MASK   8'hFE
`define RWN_OP_DISP        8'hAE
`define RWN_OP_AC_MASK     8'hF8
`define RWN_OP_AC          8'h88
`define RWN_OP_LC_MASK     8'hF8
`define RWN_OP_LC          8'hC0
`define RWN_OP_BR_MASK     8'hFC
`define RWN_OP_BR          8'hE8
`define RWN_NVM_OP_LSB     0
`define RWN_NVM_OP_MSB     2
`define RWN_NVM_EN_BIT     3
`define RWN_NVM_VALID_BIT  4
`define RWN_NVM_TEST_BIT   5
`define RWN_NVM_OP_IDLE    3'h0
`define RWN_NVM_OP_READ    3'h1
`define RWN_NVM_OP_ERASE   3'h2
`define RWN_NVM_OP_PROG    3'h3
`define RWN_AC_WRAP_BIT    0
`define RWN_AC_ORDER_BIT   1
`define RWN_AC_ROWDIR_BIT  2
`define RWN_LC_MIRROR_BIT  1
`define RWN_BR_SEL_ZERO    2'h0
`define RWN_BR_SEL_TWO     2'h2
`define RWN_COL_TOP        7'h7F
`define RWN_COL_END_RST    5'h1F
`define RWN_ROW_END_RST    7'h7F
`define RWN_NVM_OP_CYCLES  8
`endif

// *** core/rwn_addr_step.v ***
/*
 Window address stepper: next column/row for one data write.
 Assumes bounds already captured; purely combinational.
*/
`default_nettype none
module rwn_addr_step #(
  parameter CW = 5,
  parameter RW = 7
) (
  input  wire [CW-1:0] col,
  input  wire [RW-1:0] row,
  input  wire [CW-1:0] col_lo,
  input  wire [CW-1:0] col_hi,
  input  wire [RW-1:0] row_start,
  input  wire [RW-1:0] row_end,
  input  wire          row_dir,
  input  wire          order_vert,
  input  wire          wrap_adv,
  output reg  [CW-1:0] col_nxt,
  output reg  [RW-1:0] row_nxt
);
  wire          col_last = (col == col_hi);
  wire          row_last = (row == (row_dir ? row_start : row_end));
  wire [RW-1:0] row_first = row_dir ? row_end : row_start;
  wire [RW-1:0] row_step = row_dir ? row - 1'b1 : row + 1'b1;
  always @* begin
    col_nxt = col;
    row_nxt = row;
    if (order_vert) begin
      if (!row_last) begin
        row_nxt = row_step;
      end else begin
        row_nxt = row_first;
        if (wrap_adv) begin
          col_nxt = col_last ? col_lo : col + 1'b1;
        end
      end
    end else begin
      if (!col_last) begin
        col_nxt = col + 1'b1;
      end else begin
        col_nxt = col_lo;
        if (wrap_adv) begin
          row_nxt = row_last ? row_first : row_step;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** core/rwn_cmd.v ***
/*
 Command interpreter for the RAM update window and nonvolatile control.
 Assumes host bytes arrive as a one-cycle strobe with command/data select,
 synchronous to sys_clk; NVM macro reports completion by nvm_done.
*/
// Behaviour
// - Two-byte command loads five-bit window start column.
// - Two-byte command loads seven-bit window start row.
// - Two-byte command loads five-bit window end column.
// - Two-byte command loads seven-bit window end row.
// - Single-byte command sets window enable from its low bit.
// - With window on, address stepping stays inside the bounds.
// - Wrap bit decides moving to next row or column at boundary.
// - Row direction bit zero: start to end; one: reversed.
// - Order bit one steps vertically, zero horizontally.
// - Mirror on maps column to 127 minus window column.
// - Nonvolatile control low three bits select idle/read/erase/program.
// - Nonvolatile enable clears itself when the operation completes.
// - Valid bit low makes the stored nonvolatile value ignored.
// - Mask, trims and timers act only while nonvolatile enable is one.
// - Display enable and nonvolatile enable are never both on.
// - Mask load; mask ones program bits to one, zeros leave them.
// - First trim value applies to bias ratio setting zero.
// - Second trim value applies to bias ratio setting two.
// - Display enable command; clearing it idles drivers into sleep.
`default_nettype none
`include "rwn_regs.vh"
module rwn_cmd #(
  parameter NVM_W = 6,
  parameter PAR_W = 8
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire             host_wr,
  input  wire             host_cd,
  input  wire [7:0]       host_byte,
  input  wire             nvm_done,
  input  wire [NVM_W-1:0] nvm_stored,
  output reg              window_enable_bit,
  output reg  [6:0]       column_address,
  output reg  [6:0]       row_address,
  output reg              display_enable_flag,
  output reg  [2:0]       nvm_op,
  output reg              nvm_start,
  output reg  [NVM_W-1:0] nvm_write_mask,
  output reg  [NVM_W-1:0] nvm_prog_bits,
  output reg  [NVM_W-1:0] nvm_value,
  output reg              nvm_test,
  output reg  [PAR_W-1:0] trim_pot_one,
  output reg  [PAR_W-1:0] trim_pot_two,
  output reg  [PAR_W-1:0] trim_pot_active,
  output reg  [PAR_W-1:0] nvm_write_timer,
  output reg  [PAR_W-1:0] nvm_read_timer
);
  localparam ST_OP  = 1'b0;
  localparam ST_PAR = 1'b1;
  reg        state_r;
  reg [7:0]  op_r;
  reg [4:0]  window_start_column;
  reg [6:0]  window_start_row;
  reg [4:0]  window_end_column;
  reg [6:0]  window_end_row;
  reg [5:0]  nvm_control;
  reg        wrap_advance_bit;
  reg        increment_order_bit;
  reg        row_direction_bit;
  reg        column_mirror_bit;
  reg [1:0]  bias_ratio_select;
  reg [4:0]  col_r;
  wire [4:0] col_nxt;
  wire [6:0] row_nxt;
  wire       cmd = host_wr & ~host_cd;
  wire       dat = host_wr & host_cd;
  wire       nvm_en = nvm_control[`RWN_NVM_EN_BIT];

  // Double-byte opcodes; window and trim/timer commands share four of them
  wire       op_sc     = (host_byte == `RWN_OP_WIN_SC);
  wire       op_sr     = (host_byte == `RWN_OP_WIN_SR);
  wire       op_ec     = (host_byte == `RWN_OP_WIN_EC);
  wire       op_er     = (host_byte == `RWN_OP_WIN_ER);
  wire       op_nctl   = (host_byte == `RWN_OP_NVM_CTL);
  wire       op_nmask  = (host_byte == `RWN_OP_NVM_MASK);
  wire       two_byte  = op_sc | op_sr | op_ec | op_er | op_nctl | op_nmask;

  // Single-byte groups, decoded by masked compare
  wire       op_win_en = ((host_byte & `RWN_OP_WIN_EN_MASK) == `RWN_OP_WIN_EN);
  wire       op_disp   = ((host_byte & `RWN_OP_DISP_MASK) == `RWN_OP_DISP);
  wire       op_ac     = ((host_byte & `RWN_OP_AC_MASK) == `RWN_OP_AC);
  wire       op_lc     = ((host_byte & `RWN_OP_LC_MASK) == `RWN_OP_LC);
  wire       op_br     = ((host_byte & `RWN_OP_BR_MASK) == `RWN_OP_BR);

  // Operation field decodes for the derived outputs
  wire [2:0] nvm_sel   = nvm_control[`RWN_NVM_OP_MSB:`RWN_NVM_OP_LSB];
  wire       is_prog   = (nvm_sel == `RWN_NVM_OP_PROG);

  // Window off means the full array, so stepping stays sane before setup
  wire [4:0] col_lo = window_enable_bit ? window_start_column : 5'h00;
  wire [4:0] col_hi = window_enable_bit ? window_end_column : `RWN_COL_END_RST;
  wire [6:0] row_s  = window_enable_bit ? window_start_row : 7'h00;
  wire [6:0] row_e  = window_enable_bit ? window_end_row : `RWN_ROW_END_RST;
  wire [6:0] col_ext = {2'h0, col_r};

  // Next-address logic kept apart so the stepping rules read on their own
  rwn_addr_step #(
    .CW (5),
    .RW (7)
  ) u_step (
    .col        (col_r),
    .row        (row_address),
    .col_lo     (col_lo),
    .col_hi     (col_hi),
    .row_start  (row_s),
    .row_end    (row_e),
    .row_dir    (row_direction_bit),
    .order_vert (increment_order_bit),
    .wrap_adv   (wrap_advance_bit),
    .col_nxt    (col_nxt),
    .row_nxt    (row_nxt)
  );
  // Parameter byte must be a command byte too; data writes do not consume it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r             <= ST_OP;
      op_r                <= 8'h00;
      window_start_column <= 5'h00;
      window_start_row    <= 7'h00;
      window_end_column   <= `RWN_COL_END_RST;
      window_end_row      <= `RWN_ROW_END_RST;
      window_enable_bit   <= 1'b0;
      nvm_control         <= 6'h00;
      nvm_write_mask      <= {NVM_W{1'b0}};
      trim_pot_one        <= {PAR_W{1'b0}};
      trim_pot_two        <= {PAR_W{1'b0}};
      nvm_write_timer     <= {PAR_W{1'b0}};
      nvm_read_timer      <= {PAR_W{1'b0}};
      display_enable_flag <= 1'b0;
      wrap_advance_bit    <= 1'b0;
      increment_order_bit <= 1'b0;
      row_direction_bit   <= 1'b0;
      column_mirror_bit   <= 1'b0;
      bias_ratio_select   <= 2'h0;
      nvm_start           <= 1'b0;
      col_r               <= 5'h00;
      row_address         <= 7'h00;
    end else begin
      // Start is a single-cycle request to the nonvolatile macro
      nvm_start <= 1'b0;
      // Done clears enable; a control write in the same cycle wins below
      if (nvm_done && nvm_en) begin
        nvm_control[`RWN_NVM_EN_BIT] <= 1'b0;
      end
      case (state_r)
        ST_OP: begin
          if (cmd) begin
            op_r <= host_byte;
            if (two_byte) begin
              state_r <= ST_PAR;
            end else if (op_win_en) begin
              // Address restarts at the window corner on every enable write
              window_enable_bit <= host_byte[0];
              col_r             <= window_start_column;
              row_address       <= row_direction_bit ? window_end_row : window_start_row;
            end else if (op_disp) begin
              // Setting is refused during a nonvolatile operation; clearing never is
              if (!(host_byte[0] && nvm_en)) begin
                display_enable_flag <= host_byte[0];
              end
            end else if (op_ac) begin
              wrap_advance_bit    <= host_byte[`RWN_AC_WRAP_BIT];
              increment_order_bit <= host_byte[`RWN_AC_ORDER_BIT];
              row_direction_bit   <= host_byte[`RWN_AC_ROWDIR_BIT];
            end else if (op_lc) begin
              column_mirror_bit <= host_byte[`RWN_LC_MIRROR_BIT];
            end else if (op_br) begin
              bias_ratio_select <= host_byte[1:0];
            end
          end else if (dat) begin
            col_r       <= col_nxt;
            row_address <= row_nxt;
          end
        end
        ST_PAR: begin
          if (cmd) begin
            state_r <= ST_OP;
            // Shared opcodes: trims/timers win while nonvolatile enable is set
            case (op_r)
              `RWN_OP_WIN_SC: begin
                if (nvm_en) begin
                  trim_pot_one <= host_byte[PAR_W-1:0];
                end else begin
                  window_start_column <= host_byte[4:0];
                end
              end
              `RWN_OP_WIN_SR: begin
                if (nvm_en) begin
                  trim_pot_two <= host_byte[PAR_W-1:0];
                end else begin
                  window_start_row <= host_byte[6:0];
                end
              end
              `RWN_OP_WIN_EC: begin
                if (nvm_en) begin
                  nvm_write_timer <= host_byte[PAR_W-1:0];
                end else begin
                  window_end_column <= host_byte[4:0];
                end
              end
              `RWN_OP_WIN_ER: begin
                if (nvm_en) begin
                  nvm_read_timer <= host_byte[PAR_W-1:0];
                end else begin
                  window_end_row <= host_byte[6:0];
                end
              end
              `RWN_OP_NVM_CTL: begin
                nvm_control <= host_byte[5:0];
                if (display_enable_flag) begin
                  nvm_control[`RWN_NVM_EN_BIT] <= 1'b0;
                end else if (host_byte[`RWN_NVM_EN_BIT]) begin
                  nvm_start <= 1'b1;
                end
              end
              `RWN_OP_NVM_MASK: begin
                if (nvm_en) begin
                  nvm_write_mask <= host_byte[NVM_W-1:0];
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: state_r <= ST_OP;
      endcase
    end
  end

  // Registered derived outputs, one edge behind the state they follow
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      column_address  <= 7'h00;
      nvm_op          <= `RWN_NVM_OP_IDLE;
      nvm_prog_bits   <= {NVM_W{1'b0}};
      nvm_value       <= {NVM_W{1'b0}};
      nvm_test        <= 1'b0;
      trim_pot_active <= {PAR_W{1'b0}};
    end else begin
      // Mirror only remaps the address; stepping itself stays unmirrored
      if (column_mirror_bit) begin
        column_address <= `RWN_COL_TOP - col_ext;
      end else begin
        column_address <= col_ext;
      end
      if (nvm_en) begin
        nvm_op <= nvm_sel;
      end else begin
        nvm_op <= `RWN_NVM_OP_IDLE;
      end
      // Mask reaches the cells only during an enabled program operation
      if (nvm_en && is_prog) begin
        nvm_prog_bits <= nvm_write_mask;
      end else begin
        nvm_prog_bits <= {NVM_W{1'b0}};
      end
      if (nvm_control[`RWN_NVM_VALID_BIT]) begin
        nvm_value <= nvm_stored;
      end else begin
        nvm_value <= {NVM_W{1'b0}};
      end
      nvm_test <= nvm_control[`RWN_NVM_TEST_BIT];
      // Bias settings one and three have no trim of their own
      case (bias_ratio_select)
        `RWN_BR_SEL_ZERO: trim_pot_active <= trim_pot_one;
        `RWN_BR_SEL_TWO:  trim_pot_active <= trim_pot_two;
        default:          trim_pot_active <= {PAR_W{1'b0}};
      endcase
    end
  end

endmodule
`default_nettype wire

// *** bench/rwn_cmd_chk.sv ***
/*
 Port checker for the window and nonvolatile command interpreter.
 Bound to rwn_cmd from the testbench; sees only its ports.
*/
`default_nettype none
module rwn_cmd_chk #(
  parameter int NVM_W = 6,
  parameter int PAR_W = 8
) (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             host_wr,
  input wire logic             host_cd,
  input wire logic             nvm_done,
  input wire logic             window_enable_bit,
  input wire logic [6:0]       row_address,
  input wire logic             display_enable_flag,
  input wire logic [2:0]       nvm_op,
  input wire logic             nvm_start,
  input wire logic [NVM_W-1:0] nvm_write_mask,
  input wire logic [NVM_W-1:0] nvm_prog_bits,
  input wire logic [PAR_W-1:0] trim_pot_one
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_start_excl: assert property (nvm_start |-> !display_enable_flag)
    else $error("nvm start while display on");
  a_start_pulse: assert property (nvm_start |=> !nvm_start)
    else $error("nvm start longer than one cycle");
  a_op_clear: assert property (nvm_done && !host_wr |=> ##1 nvm_op == 3'h0)
    else $error("nvm op not cleared after done");
  a_win_hold: assert property (!host_wr |=> $stable(window_enable_bit))
    else $error("window enable moved without a byte");
  a_disp_hold: assert property (!host_wr |=> $stable(display_enable_flag))
    else $error("display enable moved without a byte");
  a_trim_cause: assert property ($changed(trim_pot_one) |-> $past(host_wr) && !$past(host_cd))
    else $error("trim changed without a command byte");
  a_mask_cause: assert property ($changed(nvm_write_mask) |-> $past(host_wr) && !$past(host_cd))
    else $error("mask changed without a command byte");
  a_prog_op: assert property (nvm_prog_bits != '0 |-> nvm_op == 3'h3)
    else $error("program bits outside program op");
  a_row_cause: assert property ($changed(row_address)
    |-> $past(host_wr) || $past(host_wr, 2) || $past(host_wr, 3))
    else $error("row address moved without a write");
endmodule
`default_nettype wire

// *** bench/rwn_nvm_model.sv ***
/*
 Behavioural nonvolatile macro: answers each start with a done pulse.
 Assumes one operation at a time; slow selects a long answer.
*/
`default_nettype none
`include "rwn_regs.vh"
module rwn_nvm_model #(
  parameter logic [5:0] STORED = 6'h2D
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       nvm_start,
  input  wire logic       slow,
  output var  logic       nvm_done,
  output wire logic [5:0] nvm_stored
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  assign nvm_stored = STORED;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      nvm_done <= 1'b0;
    end else begin
      nvm_done <= 1'b0;
      if (nvm_start && cnt_r == 8'h00)
        cnt_r <= slow ? 8'hC8 : 8'(`RWN_NVM_OP_CYCLES);
      else if (cnt_r == 8'h01) begin
        cnt_r <= 8'h00;
        nvm_done <= 1'b1;
      end else if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
/*
 Self-checking bench: host byte tasks, window stepping and nvm control.
 Assumes rwn_cmd, its header and the nvm model are compiled first.
*/
`default_nettype none
`include "rwn_regs.vh"
bind rwn_cmd rwn_cmd_chk #(.NVM_W(NVM_W), .PAR_W(PAR_W)) u_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .host_wr(host_wr), .host_cd(host_cd), .nvm_done(nvm_done),
  .window_enable_bit(window_enable_bit), .row_address(row_address),
  .display_enable_flag(display_enable_flag), .nvm_op(nvm_op), .nvm_start(nvm_start),
  .nvm_write_mask(nvm_write_mask), .nvm_prog_bits(nvm_prog_bits),
  .trim_pot_one(trim_pot_one));
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       host_wr = 1'b0;
  logic       host_cd = 1'b0;
  logic [7:0] host_byte = 8'h00;
  logic       slow = 1'b0;
  int         bad_count = 0;
  int         comparisons = 0;
  wire        nvm_done, nvm_start, window_enable_bit, display_enable_flag, nvm_test;
  wire  [5:0] nvm_stored, nvm_write_mask, nvm_prog_bits, nvm_value;
  wire  [6:0] column_address, row_address;
  wire  [2:0] nvm_op;
  wire  [7:0] trim_pot_one, trim_pot_two, trim_pot_active, nvm_write_timer, nvm_read_timer;
  always #50 sys_clk = ~sys_clk;
  rwn_cmd dut (.sys_clk(sys_clk), .rst_n(rst_n), .host_wr(host_wr), .host_cd(host_cd),
    .host_byte(host_byte), .nvm_done(nvm_done), .nvm_stored(nvm_stored),
    .window_enable_bit(window_enable_bit), .column_address(column_address),
    .row_address(row_address), .display_enable_flag(display_enable_flag), .nvm_op(nvm_op),
    .nvm_start(nvm_start), .nvm_write_mask(nvm_write_mask), .nvm_prog_bits(nvm_prog_bits),
    .nvm_value(nvm_value), .nvm_test(nvm_test), .trim_pot_one(trim_pot_one),
    .trim_pot_two(trim_pot_two), .trim_pot_active(trim_pot_active),
    .nvm_write_timer(nvm_write_timer), .nvm_read_timer(nvm_read_timer));
  rwn_nvm_model u_nvm (.sys_clk(sys_clk), .rst_n(rst_n), .nvm_start(nvm_start),
    .slow(slow), .nvm_done(nvm_done), .nvm_stored(nvm_stored));
  task automatic finish_test;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(input logic cd, input logic [7:0] b);
    @(posedge sys_clk);
    #1;
    host_wr = 1'b1;
    host_cd = cd;
    host_byte = b;
    @(posedge sys_clk);
    #1;
    host_wr = 1'b0;
  endtask
  task automatic cmd2(input logic [7:0] op, input logic [7:0] p);
    put(1'b0, op);
    put(1'b0, p);
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_done;
    int i;
    i = 0;
    while (nvm_done !== 1'b1 && i < 300) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk("nvm_done_seen", 8'(i < 300), 8'h01);
    settle;
  endtask
  task automatic win(input logic [7:0] ac, input logic [7:0] lc, input int n,
                     input logic [7:0] ec, input logic [7:0] er);
    put(1'b0, ac);
    put(1'b0, lc);
    put(1'b0, 8'hF9);
    repeat (n) put(1'b1, 8'h5A);
    settle;
    chk("column_address", 8'(column_address), ec);
    chk("row_address", 8'(row_address), er);
    chk("window_enable_bit", 8'(window_enable_bit), 8'h01);
  endtask
  // About 390 cycles of tests; the limit leaves wide margin
  initial begin
    #2000000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk("display_enable_flag", 8'(display_enable_flag), 8'h00);
    put(1'b0, 8'hF8);
    cmd2(`RWN_OP_WIN_SC, 8'h05);
    cmd2(`RWN_OP_WIN_SR, 8'hAF);
    cmd2(`RWN_OP_WIN_EC, 8'h07);
    cmd2(`RWN_OP_WIN_ER, 8'h30);
    chk("display_enable_flag", 8'(display_enable_flag), 8'h00);
    win(8'h89, 8'hC0, 3, 8'h05, 8'h30);
    win(8'h8D, 8'hC0, 1, 8'h06, 8'h30);
    win(8'h8B, 8'hC0, 2, 8'h06, 8'h2F);
    win(8'h89, 8'hC2, 1, 8'h79, 8'h2F);
    put(1'b0, 8'hF8);
    settle;
    chk("window_enable_bit", 8'(window_enable_bit), 8'h00);
    for (int k = 0; k < 4; k++) begin
      cmd2(`RWN_OP_NVM_CTL, 8'h18 | k[7:0]);
      settle;
      chk("nvm_op", 8'(nvm_op), k[7:0]);
      wait_done;
      chk("nvm_op", 8'(nvm_op), 8'h00);
    end
    chk("nvm_value", 8'(nvm_value), 8'h2D);
    slow = 1'b1;
    cmd2(`RWN_OP_NVM_CTL, 8'h1B);
    cmd2(`RWN_OP_NVM_MASK, 8'h2A);
    cmd2(`RWN_OP_WIN_SC, 8'h33);
    cmd2(`RWN_OP_WIN_SR, 8'h44);
    cmd2(`RWN_OP_WIN_EC, 8'h55);
    cmd2(`RWN_OP_WIN_ER, 8'h66);
    put(1'b0, 8'hAF);
    put(1'b0, 8'hE8);
    settle;
    chk("trim_pot_active", trim_pot_active, 8'h33);
    put(1'b0, 8'hEA);
    settle;
    chk("trim_pot_active", trim_pot_active, 8'h44);
    put(1'b0, 8'hE9);
    settle;
    chk("trim_pot_active", trim_pot_active, 8'h00);
    chk("display_enable_flag", 8'(display_enable_flag), 8'h00);
    chk("nvm_prog_bits", 8'(nvm_prog_bits), 8'h2A);
    chk("nvm_write_timer", nvm_write_timer, 8'h55);
    chk("nvm_read_timer", nvm_read_timer, 8'h66);
    chk("trim_pot_two", trim_pot_two, 8'h44);
    chk("nvm_test", 8'(nvm_test), 8'h00);
    wait_done;
    slow = 1'b0;
    chk("nvm_prog_bits", 8'(nvm_prog_bits), 8'h00);
    cmd2(`RWN_OP_NVM_MASK, 8'h15);
    settle;
    chk("nvm_write_mask", 8'(nvm_write_mask), 8'h2A);
    put(1'b0, 8'hAF);
    settle;
    chk("display_enable_flag", 8'(display_enable_flag), 8'h01);
    cmd2(`RWN_OP_NVM_CTL, 8'h19);
    settle;
    chk("nvm_op", 8'(nvm_op), 8'h00);
    cmd2(`RWN_OP_NVM_CTL, 8'h01);
    settle;
    chk("nvm_value", 8'(nvm_value), 8'h00);
    put(1'b0, 8'hAE);
    settle;
    chk("display_enable_flag", 8'(display_enable_flag), 8'h00);
    finish_test;
  end
endmodule
`default_nettype wire
